// file: hdl/cbd_alu.sv
// Purpose: Clear, flag reset, compare, decimal add and decrement
//          datapath with call target fetch, reached over Wishbone
// Assumes: Single clock mclk, synchronous active-high rst
// Notes:   Operand and control writes are dropped while busy
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "cbd_defines.svh"
module cbd_alu
(
   input  logic        mclk,
   input  logic        rst,
   input  logic        ce,
   input  logic        cyc_i,
   input  logic        stb_i,
   input  logic        we_i,
   input  logic [7:0]  adr_i,
   input  logic [3:0]  sel_i,
   input  logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic        ack_o,
   output logic        mem_rd_req,
   output logic [19:0] mem_addr,
   input  logic [15:0] mem_rdata,
   input  logic        mem_ack,
   output logic [15:0] status_word,
   output logic        busy
);
   cbd_pkg::cbd_state_t st_r;
   cbd_pkg::cbd_state_t st_nxt;
   cbd_pkg::cbd_op_t    op_r;
   cbd_pkg::cbd_op_t    op_nxt;
   logic        byte_r;
   logic        byte_nxt;
   logic [19:0] dst_r;
   logic [19:0] dst_nxt;
   logic [15:0] src_r;
   logic [15:0] src_nxt;
   logic [15:0] stat_r;
   logic [15:0] stat_nxt;
   logic [19:0] ptr_r;
   logic [19:0] ptr_nxt;
   logic [15:0] tgt_r;
   logic [15:0] tgt_nxt;
   logic [19:0] addr_r;
   logic [19:0] addr_nxt;
   logic        rdq_r;
   logic        rdq_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   logic [31:0] view;
   logic [31:0] wm;
   logic        req;
   logic        wr_en;
   logic [15:0] sub_b;
   logic [15:0] sub_d;
   logic        sub_n;
   logic        sub_z;
   logic        sub_c;
   logic        sub_v;
   logic [15:0] bcd_b;
   logic [15:0] bcd_s;
   logic        bcd_c;

   // Byte-lane merge of a write into the current register view
   function automatic logic [31:0] cbd_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++)
      begin
         if (sel[k])
            r[8*k+:8] = nw[8*k+:8];
      end
      return r;
   endfunction : cbd_merge

   // Only N, Z, C and optionally V change; mode bits ride through
   function automatic logic [15:0] cbd_flags(input logic [15:0] s,
                                             input logic n,
                                             input logic z,
                                             input logic c,
                                             input logic v,
                                             input logic upd_v);
      logic [15:0] r;
      r = s;
      r[`CBD_N] = n;
      r[`CBD_Z] = z;
      r[`CBD_C] = c;
      if (upd_v)
         r[`CBD_V] = v;
      return r;
   endfunction : cbd_flags

   // Operand selection for the two arithmetic units
   assign sub_b = (op_r == cbd_pkg::CBD_OP_CMP)  ? src_r :
                  (op_r == cbd_pkg::CBD_OP_DEC1) ? 16'h0001 : 16'h0002;
   assign bcd_b = (op_r == cbd_pkg::CBD_OP_DECIMAL_CARRY_ADD_OP) ? 16'h0000 : src_r;

   cbd_sub #(.W(16)) u_sub
   (
      .a       (dst_r[15:0]),
      .b       (sub_b),
      .byte_op (byte_r),
      .diff    (sub_d),
      .n       (sub_n),
      .z       (sub_z),
      .c       (sub_c),
      .v       (sub_v)
   );

   cbd_bcd #(.DIGITS(4)) u_bcd
   (
      .a       (dst_r[15:0]),
      .b       (bcd_b),
      .cin     (stat_r[`CBD_C]),
      .byte_op (byte_r),
      .sum     (bcd_s),
      .cout    (bcd_c)
   );

   // Bus request is taken once; writes only land while idle
   assign req   = cyc_i & stb_i & ~ack_r;
   assign wr_en = req & we_i & (st_r == cbd_pkg::CBD_IDLE);

   // Register view, shared by read data and byte-lane merge
   always_comb
   begin
      unique case (adr_i)
         `CBD_A_CTRL: view = {23'h0, busy, 3'h0, byte_r, op_r};
         `CBD_A_DST:  view = {12'h0, dst_r};
         `CBD_A_SRC:  view = {16'h0, src_r};
         `CBD_A_STAT: view = {16'h0, stat_r};
         `CBD_A_PTR:  view = {12'h0, ptr_r};
         `CBD_A_TGT:  view = {16'h0, tgt_r};
         default:     view = 32'h0000_0000;
      endcase
      wm      = cbd_merge(view, dat_i, sel_i);
      ack_nxt = req;
      rd_nxt  = (req & ~we_i) ? view : rd_r;
   end

   // Bus answer one cycle after the request, dropped next cycle
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
         rd_r  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         ack_r <= ack_nxt;
         rd_r  <= rd_nxt;
      end
   end

   // Sequencer and datapath next values
   always_comb
   begin
      st_nxt   = st_r;
      op_nxt   = op_r;
      byte_nxt = byte_r;
      dst_nxt  = dst_r;
      src_nxt  = src_r;
      stat_nxt = stat_r;
      ptr_nxt  = ptr_r;
      tgt_nxt  = tgt_r;
      addr_nxt = addr_r;
      rdq_nxt  = rdq_r;
      if (wr_en)
      begin
         unique case (adr_i)
            `CBD_A_CTRL:
            begin
               op_nxt   = cbd_pkg::cbd_op_t'(wm[3:0]);
               byte_nxt = wm[`CBD_CTRL_BYTE];
               st_nxt   = cbd_pkg::CBD_EXEC;
            end
            `CBD_A_DST:  dst_nxt  = wm[19:0];
            `CBD_A_SRC:  src_nxt  = wm[15:0];
            `CBD_A_STAT: stat_nxt = wm[15:0];
            `CBD_A_PTR:  ptr_nxt  = wm[19:0];
            default:     ;
         endcase
      end
      unique case (st_r)
         cbd_pkg::CBD_IDLE: ;
         cbd_pkg::CBD_EXEC:
         begin
            st_nxt = cbd_pkg::CBD_IDLE;
            unique case (op_r)
               cbd_pkg::CBD_OP_NONE: ;
               cbd_pkg::CBD_OP_ZERO: dst_nxt = 20'h00000;
               // Flag resets are word-wide, whatever the width bit
               cbd_pkg::CBD_OP_RSTC: stat_nxt = stat_r & ~`CBD_MASK_C;
               cbd_pkg::CBD_OP_RSTN: stat_nxt = stat_r & ~`CBD_MASK_N;
               cbd_pkg::CBD_OP_RSTZ: stat_nxt = stat_r & ~`CBD_MASK_Z;
               // Result dropped, destination incl. upper bits kept
               cbd_pkg::CBD_OP_CMP:
                  stat_nxt = cbd_flags(stat_r, sub_n, sub_z, sub_c, sub_v, 1'b1);
               // Overflow is undefined here, so it is left as it was
               cbd_pkg::CBD_OP_DECIMAL_ADD_OP, cbd_pkg::CBD_OP_DECIMAL_CARRY_ADD_OP:
               begin
                  dst_nxt  = {4'h0, bcd_s};
                  stat_nxt = cbd_flags(stat_r, byte_r ? bcd_s[7] : bcd_s[15],
                                       bcd_s == 16'h0000, bcd_c, 1'b0, 1'b0);
               end
               cbd_pkg::CBD_OP_DEC1, cbd_pkg::CBD_OP_DEC2:
               begin
                  dst_nxt  = {4'h0, sub_d};
                  stat_nxt = cbd_flags(stat_r, sub_n, sub_z, sub_c, sub_v, 1'b1);
               end
               cbd_pkg::CBD_OP_CALLI:
               begin
                  addr_nxt = ptr_r;
                  rdq_nxt  = 1'b1;
                  st_nxt   = cbd_pkg::CBD_FETCH;
               end
               cbd_pkg::CBD_OP_CALLX:
               begin
                  addr_nxt = ptr_r + {{4{src_r[15]}}, src_r};
                  rdq_nxt  = 1'b1;
                  st_nxt   = cbd_pkg::CBD_FETCH;
               end
               default: ;
            endcase
         end
         // Target is 16 bits, so a call always lands in the low 64 KB
         cbd_pkg::CBD_FETCH:
         begin
            if (mem_ack)
            begin
               tgt_nxt = mem_rdata;
               rdq_nxt = 1'b0;
               st_nxt  = cbd_pkg::CBD_IDLE;
               if (op_r == cbd_pkg::CBD_OP_CALLI)
                  ptr_nxt = ptr_r + `CBD_PTR_STEP;
            end
         end
         default: st_nxt = cbd_pkg::CBD_IDLE;
      endcase
   end

   // Datapath registers, frozen while ce is low
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_r   <= cbd_pkg::CBD_IDLE;
         op_r   <= cbd_pkg::CBD_OP_NONE;
         byte_r <= 1'b0;
         dst_r  <= 20'h00000;
         src_r  <= 16'h0000;
         stat_r <= `CBD_STAT_RST;
         ptr_r  <= 20'h00000;
         tgt_r  <= 16'h0000;
         addr_r <= 20'h00000;
         rdq_r  <= 1'b0;
      end
      else if (ce)
      begin
         st_r   <= st_nxt;
         op_r   <= op_nxt;
         byte_r <= byte_nxt;
         dst_r  <= dst_nxt;
         src_r  <= src_nxt;
         stat_r <= stat_nxt;
         ptr_r  <= ptr_nxt;
         tgt_r  <= tgt_nxt;
         addr_r <= addr_nxt;
         rdq_r  <= rdq_nxt;
      end
   end

   assign dat_o       = rd_r;
   assign ack_o       = ack_r;
   assign mem_rd_req  = rdq_r;
   assign mem_addr    = addr_r;
   assign status_word = stat_r;
   assign busy        = (st_r != cbd_pkg::CBD_IDLE);

   // Checks on the executing and fetch steps and on the mode bits
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   logic ex;
   assign ex = ce & (st_r == cbd_pkg::CBD_EXEC);

   property p_zero;
      ex && op_r == cbd_pkg::CBD_OP_ZERO |=> dst_r == 20'h00000 && $stable(stat_r);
   endproperty
   a_zero: assert property (p_zero) else $error("clear left data or flags");

   property p_rstc;
      ex && op_r == cbd_pkg::CBD_OP_RSTC |=> stat_r == ($past(stat_r) & 16'hFFFE);
   endproperty
   a_rstc: assert property (p_rstc) else $error("carry reset wrong");

   property p_rstn;
      ex && op_r == cbd_pkg::CBD_OP_RSTN |=> stat_r == ($past(stat_r) & 16'hFFFB);
   endproperty
   a_rstn: assert property (p_rstn) else $error("negative reset wrong");

   property p_rstz;
      ex && op_r == cbd_pkg::CBD_OP_RSTZ |=> stat_r == ($past(stat_r) & 16'hFFFD);
   endproperty
   a_rstz: assert property (p_rstz) else $error("zero reset wrong");

   property p_cmp_keep;
      ex && op_r == cbd_pkg::CBD_OP_CMP |=> $stable(dst_r);
   endproperty
   a_cmp_keep: assert property (p_cmp_keep) else $error("compare wrote dst");

   property p_cmp_eq;
      ex && op_r == cbd_pkg::CBD_OP_CMP && !byte_r && dst_r[15:0] == src_r
      |=> stat_r[`CBD_Z] && stat_r[`CBD_C] && !stat_r[`CBD_N] && !stat_r[`CBD_V];
   endproperty
   a_cmp_eq: assert property (p_cmp_eq) else $error("equal compare flags");

   property p_dec_v;
      ex && op_r == cbd_pkg::CBD_OP_DEC1 && !byte_r && dst_r[15:0] == 16'h8000
      |=> dst_r == 20'h07FFF && stat_r[`CBD_V] && stat_r[`CBD_C];
   endproperty
   a_dec_v: assert property (p_dec_v) else $error("decrement overflow");

   property p_decrement_two_op;
      ex && op_r == cbd_pkg::CBD_OP_DEC2 && !byte_r
      |=> dst_r[15:0] == $past(dst_r[15:0]) - 16'h0002;
   endproperty
   a_decrement_two_op: assert property (p_decrement_two_op) else $error("decrement by two");

   property p_mode;
      ce && !(wr_en && adr_i == `CBD_A_STAT) |=> $stable(stat_r[5:3]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode bits moved");

   property p_calli;
      ce && st_r == cbd_pkg::CBD_FETCH && mem_ack && op_r == cbd_pkg::CBD_OP_CALLI
      |=> ptr_r == $past(ptr_r) + 20'h00002 && tgt_r == $past(mem_rdata) && !busy;
   endproperty
   a_calli: assert property (p_calli) else $error("autoincrement fetch");

   c_cmp:  cover property (ex && op_r == cbd_pkg::CBD_OP_CMP);
   c_decimal_add_op: cover property (ex && op_r == cbd_pkg::CBD_OP_DECIMAL_ADD_OP && bcd_c);
   c_call: cover property (ce && st_r == cbd_pkg::CBD_FETCH && mem_ack);

endmodule : cbd_alu

// file: hdl/cbd_defines.svh
// Purpose: Offsets, field positions and reset values of the clear,
//          compare, decimal and decrement datapath
// Assumes: One 32-bit word per register on classic Wishbone
// Notes:   Bits above each register's width read as zero
//
// How it works
// - Clear writes zero, flags left alone
// - Carry reset uses mask one only
// - Negative reset ANDs status with FFFBh
// - Zero reset ANDs status with FFFDh
// - Flag resets always act word-wide
// - Autoincrement call reads target, pointer plus two
// - Indexed call reads at pointer plus offset
// - Compare adds inverted source plus one, discards
// - Compare keeps destination's upper bits untouched
// - Compare sets negative, zero, carry from MSB
// - Compare overflow on signed subtraction wrap
// - Decimal add adds source and carry
// - Decimal add flags: MSB, zero, BCD carry
// - Decimal carry add adds carry only
// - Decrement one flags from old value
// - Decrement two subtracts two, overwrites destination
// - Decrement two zero and overflow from old value
// - Mode bits never touched by operations
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH

// Register byte addresses
`define CBD_A_CTRL 8'h00
`define CBD_A_DST  8'h04
`define CBD_A_SRC  8'h08
`define CBD_A_STAT 8'h0C
`define CBD_A_PTR  8'h10
`define CBD_A_TGT  8'h14

// Control register fields
`define CBD_CTRL_BYTE 4
`define CBD_CTRL_BUSY 8

// Status word bit positions
`define CBD_C    0
`define CBD_Z    1
`define CBD_N    2
`define CBD_GIE  3
`define CBD_HALT 4
`define CBD_OSC  5
`define CBD_V    8

// Flag masks, reset values and pointer step
`define CBD_MASK_C   16'h0001
`define CBD_MASK_Z   16'h0002
`define CBD_MASK_N   16'h0004
`define CBD_STAT_RST 16'h0000
`define CBD_PTR_STEP 20'h00002

`endif

// file: hdl/cbd_pkg.sv
// Purpose: Types shared by the datapath files
// Assumes: Operation codes are the values software writes to control
// Notes:   Codes above the last operation are ignored
package cbd_pkg;

   // Operation codes seen by software
   typedef enum logic [3:0] {
      CBD_OP_NONE  = 4'h0,
      CBD_OP_ZERO  = 4'h1,
      CBD_OP_RSTC  = 4'h2,
      CBD_OP_RSTN  = 4'h3,
      CBD_OP_RSTZ  = 4'h4,
      CBD_OP_CMP   = 4'h5,
      CBD_OP_DECIMAL_ADD_OP  = 4'h6,
      CBD_OP_DECIMAL_CARRY_ADD_OP  = 4'h7,
      CBD_OP_DEC1  = 4'h8,
      CBD_OP_DEC2  = 4'h9,
      CBD_OP_CALLI = 4'hA,
      CBD_OP_CALLX = 4'hB
   } cbd_op_t;

   // Sequencer states
   typedef enum logic [1:0] {CBD_IDLE, CBD_EXEC, CBD_FETCH} cbd_state_t;

endpackage : cbd_pkg

// file: hdl/cbd_sub.sv
// Purpose: Subtractor with status flags for compare and decrements
// Assumes: Operands already chosen by the caller
// Notes:   Byte form zeroes the upper result bits
`timescale 1ns/1ns
module cbd_sub
#(
   parameter int W = 16
)
(
   input  logic [W-1:0] a,
   input  logic [W-1:0] b,
   input  logic         byte_op,
   output logic [W-1:0] diff,
   output logic         n,
   output logic         z,
   output logic         c,
   output logic         v
);
   logic [W:0] sw;
   logic [8:0] sb;

   // Inverted source plus one, carry is out of the MSB
   assign sw   = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, 1'b1};
   assign sb   = {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + 9'h001;
   // Byte form works on bit seven
   assign diff = byte_op ? {{(W-8){1'b0}}, sb[7:0]} : sw[W-1:0];
   assign n    = byte_op ? sb[7] : sw[W-1];
   assign z    = byte_op ? (sb[7:0] == 8'h00) : (sw[W-1:0] == '0);
   assign c    = byte_op ? sb[8] : sw[W];
   // Signs differ and result sign left the destination's
   assign v    = byte_op ? ((a[7] ^ b[7]) & (sb[7] ^ a[7]))
                         : ((a[W-1] ^ b[W-1]) & (sw[W-1] ^ a[W-1]));

endmodule : cbd_sub

// file: hdl/cbd_bcd.sv
// Purpose: Packed BCD adder with carry chain
// Assumes: Inputs are valid BCD; other codes give no defined sum
// Notes:   Byte form takes its carry from the second digit
`timescale 1ns/1ns
module cbd_bcd
#(
   parameter int DIGITS = 4
)
(
   input  logic [4*DIGITS-1:0] a,
   input  logic [4*DIGITS-1:0] b,
   input  logic                cin,
   input  logic                byte_op,
   output logic [4*DIGITS-1:0] sum,
   output logic                cout
);
   logic [DIGITS:0]   cy;
   logic [4*DIGITS-1:0] raw;

   assign cy[0] = cin;

   // One decimal digit per stage, corrected by six past nine
   genvar i;
   generate
      for (i = 0; i < DIGITS; i++)
      begin : g_dig
         logic [4:0] t;
         logic [4:0] adj;
         assign t   = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, cy[i]};
         assign adj = (t > 5'h09) ? t + 5'h06 : t;
         assign raw[4*i+:4] = adj[3:0];
         assign cy[i+1] = (t > 5'h09);
      end
   endgenerate

   // Byte form keeps two digits only
   assign sum  = byte_op ? {{(4*DIGITS-8){1'b0}}, raw[7:0]} : raw;
   assign cout = byte_op ? cy[2] : cy[DIGITS];

endmodule : cbd_bcd

// file: dv/cbd_mem_model.sv
// Purpose: Memory side that answers call target reads from the datapath
// Assumes: Request and address held until ack is seen
// Notes:   Read word is the address scrambled by a fixed pattern
`timescale 1ns/1ns
module cbd_mem_model
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        mem_rd_req,
   input  wire logic [19:0] mem_addr,
   output logic      [15:0] mem_rdata,
   output logic             mem_ack,
   output logic      [19:0] last_addr
);
   logic [3:0] wait_r;

   // Answer at once or after eight cycles; idle data never keeps a stale word
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= 16'h0000;
         wait_r    <= 4'h0;
         last_addr <= 20'h00000;
      end
      else if (mem_ack)
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata; // Released: show the inverse
      end
      else if (mem_rd_req && wait_r >= (slow ? 4'h8 : 4'h0))
      begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_addr[15:0] ^ 16'hA5C3;
         last_addr <= mem_addr;
         wait_r    <= 4'h0;
      end
      else
      begin
         wait_r    <= mem_rd_req ? wait_r + 4'h1 : 4'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : cbd_mem_model

// file: dv/cbd_alu_test.sv
// Purpose: Self-checking bench for the clear, compare, decimal, decrement datapath
// Assumes: Registers reached by classic Wishbone, one clock
// Notes:   Expected results are worked out by hand per row
`timescale 1ns/1ns
`include "cbd_defines.svh"
module cbd_alu_test;
   logic        mclk;
   logic        rst;
   logic        ce;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        req;
   logic [19:0] maddr;
   logic [15:0] mrdata;
   logic        mack;
   logic [15:0] stat;
   logic        busy;
   logic        slow;
   logic [19:0] last_addr;
   logic [31:0] q;
   logic [3:0]  sel;
   int          fails;
   int          n_checks;

   cbd_alu i_dut (.mclk(mclk), .rst(rst), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .mem_rd_req(req),
      .mem_addr(maddr), .mem_rdata(mrdata), .mem_ack(mack), .status_word(stat), .busy(busy));

   cbd_mem_model i_mem (.mclk(mclk), .rst(rst), .slow(slow), .mem_rd_req(req),
      .mem_addr(maddr), .mem_rdata(mrdata), .mem_ack(mack), .last_addr(last_addr));

   task automatic wrap_up;
      if (fails == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle; ack and read data taken at the same edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1)
      begin
         fails++;
         wrap_up();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge mclk);
   endtask : wb

   // Poll the busy bit; a stuck busy ends as a mismatch
   task automatic wait_idle;
      int k;
      k = 0;
      do
      begin
         wb(1'b0, `CBD_A_CTRL, 32'h0);
         k++;
      end
      while (q[`CBD_CTRL_BUSY] !== 1'b0 && k < 30);
      chk({31'h0, q[`CBD_CTRL_BUSY]}, 32'h0);
   endtask : wait_idle

   task automatic r(input logic [3:0] op, input logic b, input logic [19:0] d,
      input logic [15:0] s, input logic [15:0] st, input logic [19:0] ed, input logic [15:0] es);
      wb(1'b1, `CBD_A_DST, {12'h000, d});
      wb(1'b1, `CBD_A_SRC, {16'h0000, s});
      wb(1'b1, `CBD_A_STAT, {16'h0000, st});
      wb(1'b1, `CBD_A_CTRL, {27'h0, b, op});
      wait_idle();
      wb(1'b0, `CBD_A_DST, 32'h0);
      chk(q, {12'h000, ed});
      wb(1'b0, `CBD_A_STAT, 32'h0);
      chk(q, {16'h0000, es});
      chk({16'h0000, stat}, {16'h0000, es});
   endtask : r

   // Slow answer also shows busy and a dropped operand write
   task automatic call(input logic [3:0] op, input logic sl, input logic [19:0] p,
      input logic [15:0] s, input logic [19:0] ea, input logic [15:0] et, input logic [19:0] ep);
      slow <= sl;
      wb(1'b1, `CBD_A_DST, 32'h0000ABCD);
      wb(1'b1, `CBD_A_PTR, {12'h000, p});
      wb(1'b1, `CBD_A_SRC, {16'h0000, s});
      wb(1'b1, `CBD_A_CTRL, {28'h0, op});
      if (sl)
      begin
         wb(1'b1, `CBD_A_DST, 32'h00055555);
         wb(1'b0, `CBD_A_CTRL, 32'h0);
         chk({31'h0, q[`CBD_CTRL_BUSY]}, 32'h1);
         // Busy pin, request and address must stand through the slow answer
         chk({31'h0, busy}, 32'h1);
         chk({31'h0, req}, 32'h1);
         chk({12'h000, maddr}, {12'h000, ea});
      end
      wait_idle();
      chk({31'h0, req}, 32'h0);
      chk({31'h0, busy}, 32'h0);
      chk({12'h000, last_addr}, {12'h000, ea});
      wb(1'b0, `CBD_A_TGT, 32'h0);
      chk(q, {16'h0000, et});
      wb(1'b0, `CBD_A_PTR, 32'h0);
      chk(q, {12'h000, ep});
      wb(1'b0, `CBD_A_DST, 32'h0);
      chk(q, 32'h0000ABCD);
   endtask : call

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Main sequence; status base 0038h keeps the mode bits set in every row but the byte-form clear row
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      slow = 1'b0;
      sel = 4'hF;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (int a = 0; a <= 'h18; a += 4)
      begin
         wb(1'b0, 8'(a), 32'h0);
         chk(q, 32'h0);
      end
      r(cbd_pkg::CBD_OP_ZERO, 1'b0, 20'hFFFFF, 16'h0, 16'h013F, 20'h0, 16'h013F);
      r(cbd_pkg::CBD_OP_ZERO, 1'b1, 20'h12345, 16'h0, 16'h0000, 20'h0, 16'h0000);
      r(cbd_pkg::CBD_OP_RSTC, 1'b0, 20'h00ABC, 16'h0, 16'h013F, 20'h00ABC, 16'h013E);
      r(cbd_pkg::CBD_OP_RSTN, 1'b1, 20'h00ABC, 16'h0, 16'h013F, 20'h00ABC, 16'h013B);
      r(cbd_pkg::CBD_OP_RSTZ, 1'b1, 20'h00ABC, 16'h0, 16'h013F, 20'h00ABC, 16'h013D);
      r(cbd_pkg::CBD_OP_CMP, 1'b0, 20'hA1234, 16'h1234, 16'h0038, 20'hA1234, 16'h003B);
      r(cbd_pkg::CBD_OP_CMP, 1'b0, 20'h07FFF, 16'hFFFF, 16'h0038, 20'h07FFF, 16'h013C);
      r(cbd_pkg::CBD_OP_CMP, 1'b0, 20'h00001, 16'h0002, 16'h0039, 20'h00001, 16'h003C);
      r(cbd_pkg::CBD_OP_CMP, 1'b1, 20'hA5580, 16'h0001, 16'h0038, 20'hA5580, 16'h0139);
      r(cbd_pkg::CBD_OP_DECIMAL_ADD_OP, 1'b0, 20'h01999, 16'h0001, 16'h0039, 20'h02001, 16'h0038);
      r(cbd_pkg::CBD_OP_DECIMAL_ADD_OP, 1'b0, 20'h09999, 16'h0001, 16'h0138, 20'h00000, 16'h013B);
      r(cbd_pkg::CBD_OP_DECIMAL_ADD_OP, 1'b0, 20'h07999, 16'h0001, 16'h0038, 20'h08000, 16'h003C);
      r(cbd_pkg::CBD_OP_DECIMAL_ADD_OP, 1'b1, 20'h30099, 16'h0001, 16'h0038, 20'h00000, 16'h003B);
      r(cbd_pkg::CBD_OP_DECIMAL_CARRY_ADD_OP, 1'b0, 20'h09999, 16'h0, 16'h0039, 20'h00000, 16'h003B);
      r(cbd_pkg::CBD_OP_DECIMAL_CARRY_ADD_OP, 1'b0, 20'h00099, 16'h0, 16'h0039, 20'h00100, 16'h0038);
      r(cbd_pkg::CBD_OP_DECIMAL_CARRY_ADD_OP, 1'b1, 20'h00099, 16'h0, 16'h0039, 20'h00000, 16'h003B);
      r(cbd_pkg::CBD_OP_DEC1, 1'b0, 20'h00001, 16'h0, 16'h0038, 20'h00000, 16'h003B);
      r(cbd_pkg::CBD_OP_DEC1, 1'b0, 20'h00000, 16'h0, 16'h0038, 20'h0FFFF, 16'h003C);
      r(cbd_pkg::CBD_OP_DEC1, 1'b0, 20'h08000, 16'h0, 16'h0038, 20'h07FFF, 16'h0139);
      r(cbd_pkg::CBD_OP_DEC1, 1'b1, 20'h12380, 16'h0, 16'h0038, 20'h0007F, 16'h0139);
      r(cbd_pkg::CBD_OP_DEC2, 1'b0, 20'hF0002, 16'h0, 16'h0038, 20'h00000, 16'h003B);
      r(cbd_pkg::CBD_OP_DEC2, 1'b0, 20'h08001, 16'h0, 16'h0038, 20'h07FFF, 16'h0139);
      r(cbd_pkg::CBD_OP_DEC2, 1'b0, 20'h08000, 16'h0, 16'h0038, 20'h07FFE, 16'h0139);
      r(cbd_pkg::CBD_OP_DEC2, 1'b1, 20'h00081, 16'h0, 16'h0038, 20'h0007F, 16'h0139);
      r(cbd_pkg::CBD_OP_DEC2, 1'b0, 20'h00001, 16'h0, 16'h0038, 20'h0FFFF, 16'h003C);
      r(cbd_pkg::CBD_OP_NONE, 1'b0, 20'h12345, 16'h1111, 16'h0138, 20'h12345, 16'h0138);
      for (int i = 12; i < 16; i++)
      begin
         r(4'(i), 1'b0, 20'h12345, 16'h1111, 16'h0138, 20'h12345, 16'h0138);
      end
      call(cbd_pkg::CBD_OP_CALLI, 1'b1, 20'h12340, 16'h0, 20'h12340, 16'h8683, 20'h12342);
      call(cbd_pkg::CBD_OP_CALLX, 1'b0, 20'h01000, 16'hFFF0, 20'h00FF0, 16'hAA33, 20'h01000);
      // Target is read-only, unmapped space reads zero
      wb(1'b1, `CBD_A_TGT, 32'h0000FFFF);
      wb(1'b0, `CBD_A_TGT, 32'h0);
      chk(q, 32'h0000AA33);
      wb(1'b1, 8'h18, 32'hFFFFFFFF);
      wb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0);
      // Only byte lane zero of the destination takes the write
      sel <= 4'h1;
      wb(1'b1, `CBD_A_DST, 32'h00055511);
      sel <= 4'hF;
      wb(1'b0, `CBD_A_DST, 32'h0);
      chk(q, 32'h0000AB11);
      // Mid-run reset must clear status and pointer again
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk({16'h0000, stat}, 32'h0);
      wb(1'b0, `CBD_A_PTR, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, `CBD_A_TGT, 32'h0);
      chk(q, 32'h0);
      wrap_up();
   end
endmodule : cbd_alu_test
